// ---- src/lhp_port.sv ----
/*
 * Host port of a dot-matrix LCD controller: nibble or serial byte link.
 * Assumes the host pins are asynchronous to ref_clk, the strobe runs far
 * slower than ref_clk, and a command decoder drains the byte FIFO.
 */
`timescale 1ns/1ps
module lhp_port
	import lhp_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	input  wire logic                  dev_reset,
	input  wire logic [LHP_NIB_W-1:0]  nibble_bus_in,
	output logic      [LHP_NIB_W-1:0]  nibble_bus_out,
	output logic      [LHP_NIB_W-1:0]  nibble_bus_oe,
	input  wire logic                  nibble_strobe_n,
	input  wire logic                  chip_sel_n,
	input  wire logic                  cmd_data,
	input  wire logic                  die_addr_bit0,
	input  wire logic                  die_addr_bit1,
	output logic                       busy_n_out,
	output logic                       busy_n_oe,
	input  wire logic [1:0]            host_chip_addr,
	input  wire logic                  read_mode,
	input  wire logic [LHP_BYTE_W-1:0] tx_data,
	input  wire logic                  proc_done,
	output logic                       rx_valid,
	input  wire logic                  rx_ready,
	output logic      [LHP_WORD_W-1:0] rx_data,
	output logic                       serial_mode,
	output logic                       addr_enable
);
	typedef struct packed {
		logic [1:0]            strobe_s;
		logic [1:0]            cs_s;
		logic [1:0]            rst_s;
		logic [1:0]            cd_s;
		logic [1:0]            a0_s;
		logic [1:0]            a1_s;
		logic [LHP_NIB_W-1:0]  bus_s1;
		logic [LHP_NIB_W-1:0]  bus_s2;
		logic                  strobe_d;
		logic                  rst_d;
		lhp_mode_t             mode;
		logic                  addr_en;
		logic [2:0]            cnt;
		logic [LHP_BYTE_W-1:0] shreg;
		logic [LHP_NIB_W-1:0]  out_nib;
		logic                  busy;
		logic                  push;
		logic [LHP_WORD_W-1:0] push_word;
	} lhp_state_t;

	lhp_state_t s;
	lhp_state_t next_s;
	logic       rise;
	logic       fall;
	logic       rst_fall;
	logic       sel;
	logic       fifo_ready;

	// Address check used only by the selection logic; the checks use sel
	function automatic logic addr_ok(input logic en, input logic [1:0] pins,
		input logic [1:0] host);
		addr_ok = ~en | (pins == host);
	endfunction

	// ----------------------------------------------------------------
	// Edge detection and selection
	// ----------------------------------------------------------------
	assign rise     = s.strobe_s[1] & ~s.strobe_d;
	assign fall     = ~s.strobe_s[1] & s.strobe_d;
	assign rst_fall = s.rst_d & ~s.rst_s[1];
	assign sel      = ~s.cs_s[1] & addr_ok(s.addr_en,
		{s.a1_s[1], s.a0_s[1]}, host_chip_addr);

	// Next state: synchronisers, mode capture, shifting and busy
	always_comb begin
		next_s        = s;
		next_s.strobe_s = {s.strobe_s[0], nibble_strobe_n};
		next_s.cs_s   = {s.cs_s[0], chip_sel_n};
		next_s.rst_s  = {s.rst_s[0], dev_reset};
		next_s.cd_s   = {s.cd_s[0], cmd_data};
		next_s.a0_s   = {s.a0_s[0], die_addr_bit0};
		next_s.a1_s   = {s.a1_s[0], die_addr_bit1};
		next_s.bus_s1 = nibble_bus_in;
		next_s.bus_s2 = s.bus_s1;
		next_s.strobe_d = s.strobe_s[1];
		next_s.rst_d  = s.rst_s[1];
		next_s.push   = 1'b0;
		// Strap capture on device reset release, held afterwards
		if (rst_fall) begin
			next_s.mode = s.bus_s2[LHP_PIN_MODE] ?
				LHP_MODE_PAR : LHP_MODE_SER;
			next_s.addr_en = s.bus_s2[LHP_PIN_MODE] ?
				1'b1 : s.bus_s2[LHP_PIN_AEN];
		end
		if (s.rst_s[1] | ~sel) begin
			next_s.cnt = '0;
			if (s.rst_s[1])
				next_s.busy = 1'b0;
		end else if (!read_mode) begin
			if (rise && s.mode == LHP_MODE_PAR) begin
				if (s.cnt == '0) begin
					next_s.shreg[7:4] = s.bus_s2;
					next_s.cnt        = LHP_CNT_PAR_LAST;
				end else begin
					next_s.shreg[3:0] = s.bus_s2;
					next_s.cnt        = '0;
					next_s.push       = 1'b1;
				end
			end else if (rise) begin
				next_s.shreg = {s.shreg[6:0],
					s.bus_s2[LHP_PIN_SI]};
				next_s.cnt   = s.cnt + 3'h1;
				next_s.push  = (s.cnt == LHP_CNT_SER_LAST);
			end
		end else if (fall) begin
			if (s.mode == LHP_MODE_PAR) begin
				if (s.cnt == '0) begin
					next_s.out_nib = tx_data[7:4];
					next_s.shreg   = tx_data;
					next_s.cnt     = LHP_CNT_PAR_LAST;
				end else begin
					next_s.out_nib = s.shreg[3:0];
					next_s.cnt     = '0;
				end
			end else begin
				if (s.cnt == '0) begin
					next_s.out_nib[LHP_PIN_SO] = tx_data[7];
					next_s.shreg = {tx_data[6:0], 1'b0};
				end else begin
					next_s.out_nib[LHP_PIN_SO] = s.shreg[7];
					next_s.shreg = {s.shreg[6:0], 1'b0};
				end
				next_s.cnt = s.cnt + 3'h1;
			end
		end
		// Busy set wins over release in the same cycle
		if (next_s.push) begin
			next_s.busy      = 1'b1;
			next_s.push_word = {s.cd_s[1], next_s.shreg};
		end else if (s.busy & proc_done & fifo_ready) begin
			next_s.busy = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s         <= '0;
			s.strobe_s <= 2'h3;
			s.cs_s     <= 2'h3;
			s.strobe_d <= 1'b1;
			s.mode    <= LHP_MODE_PAR;
			s.addr_en <= LHP_RST_ADDR_EN;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	assign busy_n_out     = ~s.busy;
	assign busy_n_oe      = sel;
	assign nibble_bus_out = s.out_nib;
	assign nibble_bus_oe  = (sel & read_mode) ?
		((s.mode == LHP_MODE_PAR) ? LHP_OE_PAR : LHP_OE_SER) : '0;
	assign serial_mode    = (s.mode == LHP_MODE_SER);
	assign addr_enable    = s.addr_en;

	// Received bytes queue for the decoder
	lhp_fifo #(.W(LHP_WORD_W), .DEPTH(LHP_FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.in_valid  (s.push),
		.in_ready  (fifo_ready),
		.in_data   (s.push_word),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_par_wr_first;
		sel && !s.rst_s[1] && !read_mode && rise && s.mode == LHP_MODE_PAR
			&& s.cnt == 3'h0;
	endsequence
	sequence s_par_wr_second;
		sel && !s.rst_s[1] && !read_mode && rise && s.mode == LHP_MODE_PAR
			&& s.cnt == LHP_CNT_PAR_LAST;
	endsequence
	sequence s_ser_wr_last;
		sel && !s.rst_s[1] && !read_mode && rise && s.mode == LHP_MODE_SER
			&& s.cnt == LHP_CNT_SER_LAST;
	endsequence

	property p_mode_capture;
		@(posedge ref_clk) disable iff (!reset_n)
		rst_fall |=> serial_mode == !$past(s.bus_s2[1]);
	endproperty
	a_mode_capture: assert property (p_mode_capture)
		else $error("mode not taken from pin 1 at reset release");

	property p_aen_capture;
		@(posedge ref_clk) disable iff (!reset_n)
		rst_fall && !s.bus_s2[1] |=> addr_enable == $past(s.bus_s2[2]);
	endproperty
	a_aen_capture: assert property (p_aen_capture)
		else $error("address enable not taken from pin 2");

	property p_par_addr;
		@(posedge ref_clk) disable iff (!reset_n)
		!serial_mode |-> addr_enable;
	endproperty
	a_par_addr: assert property (p_par_addr)
		else $error("parallel mode without address compare");

	property p_ser_noaddr;
		@(posedge ref_clk) disable iff (!reset_n)
		serial_mode && !addr_enable |-> sel == !s.cs_s[1];
	endproperty
	a_ser_noaddr: assert property (p_ser_noaddr)
		else $error("serial select ignores address enable");

	property p_hiz;
		@(posedge ref_clk) disable iff (!reset_n)
		s.cs_s[1] |-> !busy_n_oe && nibble_bus_oe == 4'h0;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("pins driven while chip select high");

	property p_par_byte;
		@(posedge ref_clk) disable iff (!reset_n)
		s_par_wr_first |=> s.shreg[7:4] == $past(s.bus_s2)
			&& s.cnt == LHP_CNT_PAR_LAST;
	endproperty
	a_par_byte: assert property (p_par_byte)
		else $error("high nibble not stored on first rise");

	property p_par_latch;
		@(posedge ref_clk) disable iff (!reset_n)
		s_par_wr_second |=> s.push && s.push_word[3:0] == $past(s.bus_s2)
			&& s.busy;
	endproperty
	a_par_latch: assert property (p_par_latch)
		else $error("byte not latched on second rise");

	property p_ser_latch;
		@(posedge ref_clk) disable iff (!reset_n)
		s_ser_wr_last |=> s.push && s.push_word[0] == $past(s.bus_s2[0])
			&& !busy_n_out;
	endproperty
	a_ser_latch: assert property (p_ser_latch)
		else $error("busy not low after eighth clock rise");

	property p_ser_out;
		@(posedge ref_clk) disable iff (!reset_n)
		sel && !s.rst_s[1] && read_mode && fall && serial_mode
			&& s.cnt == 3'h0
			|=> nibble_bus_out[3] == $past(tx_data[7]);
	endproperty
	a_ser_out: assert property (p_ser_out)
		else $error("serial output not MSB first");

	property p_restart;
		@(posedge ref_clk) disable iff (!reset_n)
		!sel |=> s.cnt == 3'h0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("count not restarted while deselected");

endmodule // lhp_port

// ---- src/lhp_pkg.sv ----
/*
 * Constants and types for the LCD host serial/parallel port.
 * Assumes nothing of its surroundings; imported by lhp_port and lhp_fifo.
 */
package lhp_pkg;

	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int LHP_NIB_W      = 4;
	localparam int LHP_BYTE_W     = 8;
	localparam int LHP_WORD_W     = 9;   // Command flag above the byte
	localparam int LHP_FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// Shared data pin positions
	// ----------------------------------------------------------------
	localparam int LHP_PIN_SI   = 0;
	localparam int LHP_PIN_MODE = 1;
	localparam int LHP_PIN_AEN  = 2;
	localparam int LHP_PIN_SO   = 3;

	// ----------------------------------------------------------------
	// Counts, enables and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] LHP_CNT_PAR_LAST = 3'h1;
	localparam logic [2:0] LHP_CNT_SER_LAST = 3'h7;
	localparam logic [3:0] LHP_OE_PAR       = 4'hf;
	localparam logic [3:0] LHP_OE_SER       = 4'h8;
	localparam logic       LHP_RST_ADDR_EN  = 1'h1;

	// Interface mode latched at device reset release
	typedef enum logic {LHP_MODE_PAR, LHP_MODE_SER} lhp_mode_t;

endpackage

// ---- src/lhp_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock for both sides and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module lhp_fifo
	import lhp_pkg::*;
#(
	parameter int W     = LHP_WORD_W,
	parameter int DEPTH = LHP_FIFO_DEPTH
) (
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr_ptr;
		logic [AW-1:0]           rd_ptr;
		logic [AW:0]             count;
	} lhp_fifo_state_t;

	lhp_fifo_state_t s;
	lhp_fifo_state_t next_s;
	logic            push;
	logic            pop;

	// ----------------------------------------------------------------
	// Handshake
	// ----------------------------------------------------------------
	assign in_ready  = (s.count != (AW+1)'(DEPTH));
	assign out_valid = (s.count != '0);
	assign out_data  = s.mem[s.rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and occupancy update
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr_ptr] = in_data;
			next_s.wr_ptr        = AW'((s.wr_ptr + 1'b1) % DEPTH);
		end
		if (pop)
			next_s.rd_ptr = AW'((s.rd_ptr + 1'b1) % DEPTH);
		if (push & ~pop)
			next_s.count = s.count + 1'b1;
		else if (pop & ~push)
			next_s.count = s.count - 1'b1;
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s.wr_ptr <= '0;
			s.rd_ptr <= '0;
			s.count  <= '0;
			s.mem    <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule // lhp_fifo

// ---- src/lhp_port_fix.sv ----
`timescale 1ns/1ps

// ---- test/lhp_host.sv ----
/* Host model: strobe or serial clock, select, command flag, data pins.
   Assumes ref_clk from the bench; the link clock idles high between frames. */
`timescale 1ns/1ps
module lhp_host
	import lhp_pkg::*;
(
	input  wire logic [LHP_NIB_W-1:0] dev_out,
	input  wire logic [LHP_NIB_W-1:0] dev_oe,
	input  wire logic                 ref_clk,
	output logic      [LHP_NIB_W-1:0] pins,
	output logic                      strobe_n,
	output logic                      cs_n,
	output logic                      cd,
	output logic                      dev_reset
);
	// ----------------------------------------------------------------
	// Pin drive and link timing
	// ----------------------------------------------------------------
	logic [LHP_NIB_W-1:0] drv = 4'h0;
	logic [LHP_NIB_W-1:0] seen_oe;
	initial begin
		strobe_n = 1'b1;
		cs_n = 1'b1;
		cd = 1'b0;
		dev_reset = 1'b0;
	end
	// Device wins on pins it drives; released host value is inverted
	always_comb begin
		for (int i = 0; i < LHP_NIB_W; i++)
			pins[i] = dev_oe[i] ? dev_out[i] : drv[i];
	end
	// Half of the 160 ns link period
	task automatic half();
		repeat (20) @(posedge ref_clk);
		#1;
	endtask
	// Straps on the shared pins across a device reset pulse
	task automatic strap(input logic par, input logic aen);
		drv = {1'b0, aen, par, 1'b0};
		dev_reset = 1'b1;
		half();
		dev_reset = 1'b0;
		half();
		drv = ~drv;
	endtask
	// One selection holding nu nibbles or bits
	task automatic xfer(input logic ser, input int nu, input logic [7:0] wb,
		input logic c, output logic [7:0] rb);
		rb = 8'h00;
		cs_n = 1'b0;
		cd = c;
		half();
		for (int k = 0; k < nu; k++) begin
			strobe_n = 1'b0;
			if (ser)
				drv = {4{wb[7-k]}};
			else
				drv = wb[7-4*k -: 4];
			half();
			seen_oe = dev_oe;
			rb = ser ? {rb[6:0], pins[LHP_PIN_SO]} : {rb[3:0], pins};
			strobe_n = 1'b1;
			half();
		end
		cs_n = 1'b1;
		drv = ~drv;
		half();
	endtask
endmodule // lhp_host

// ---- test/lcd_host_serial_parallel_port_tb.sv ----
/* Self-checking bench of the host port against a queue model.
   Assumes the host model drives all link pins. */
`timescale 1ns/1ps
module lcd_host_serial_parallel_port_tb import lhp_pkg::*; ;
	// ----------------------------------------------------------------
	// Signals, model state and instances
	// ----------------------------------------------------------------
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [1:0]  die_addr = 2'h2;
	logic [1:0]  host_chip_addr = 2'h2;
	logic        read_mode = 1'b0;
	logic [7:0]  tx_data = 8'h00;
	logic        proc_done = 1'b0;
	logic        rx_ready = 1'b0;
	logic [3:0]  pins, bus_out, bus_oe;
	logic        strobe_n, cs_n, cd, dev_reset, busy_n_out, busy_n_oe;
	logic        rx_valid, serial_mode, addr_enable;
	logic [8:0]  rx_data;
	logic [15:0] lfsr = 16'h4aeb;
	logic        exp_ser, exp_ae, exp_busy;
	logic [8:0]  q[$];
	int          fail_count = 0;
	int          total_checks = 0;
	always #2 ref_clk = ~ref_clk;
	lhp_port dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.dev_reset(dev_reset), .nibble_bus_in(pins),
		.nibble_bus_out(bus_out), .nibble_bus_oe(bus_oe),
		.nibble_strobe_n(strobe_n), .chip_sel_n(cs_n), .cmd_data(cd),
		.die_addr_bit0(die_addr[0]), .die_addr_bit1(die_addr[1]),
		.busy_n_out(busy_n_out), .busy_n_oe(busy_n_oe),
		.host_chip_addr(host_chip_addr), .read_mode(read_mode),
		.tx_data(tx_data), .proc_done(proc_done), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data),
		.serial_mode(serial_mode), .addr_enable(addr_enable));
	lhp_host host (.dev_out(bus_out), .dev_oe(bus_oe), .ref_clk(ref_clk),
		.pins(pins), .strobe_n(strobe_n), .cs_n(cs_n), .cd(cd),
		.dev_reset(dev_reset));
	// Comparison, verdict and random source
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [15:0] step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Operations with model updates
	task automatic mode(input logic par, input logic aen);
		host.strap(par, aen);
		exp_ser = !par;
		exp_ae = par | aen;
		exp_busy = 1'b1;
		check(9'(serial_mode), 9'(exp_ser));
		check(9'(addr_enable), 9'(exp_ae));
	endtask
	task automatic wr(input logic c);
		logic [7:0] rb;
		logic       ok;
		lfsr = step(lfsr);
		ok = !exp_ae || host_chip_addr == die_addr;
		host.xfer(exp_ser, exp_ser ? 8 : 2, lfsr[7:0], c, rb);
		if (ok && q.size() < LHP_FIFO_DEPTH)
			q.push_back({c, lfsr[7:0]});
		if (ok)
			exp_busy = 1'b0;
		check(9'(busy_n_out), 9'(exp_busy));
	endtask
	task automatic release_busy();
		proc_done = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		proc_done = 1'b0;
		if (q.size() < LHP_FIFO_DEPTH)
			exp_busy = 1'b1;
		check(9'(busy_n_out), 9'(exp_busy));
	endtask
	task automatic rd();
		logic [7:0] rb;
		lfsr = step(lfsr);
		tx_data = lfsr[7:0];
		read_mode = 1'b1;
		host.xfer(exp_ser, exp_ser ? 8 : 2, 8'h00, 1'b0, rb);
		read_mode = 1'b0;
		check(9'(rb), 9'(tx_data));
		check(9'(host.seen_oe), exp_ser ? 9'h8 : 9'hf);
		check(9'({bus_oe, busy_n_oe}), 9'h0);
	endtask
	task automatic drain();
		int n;
		while (q.size() > 0) begin
			n = 0;
			while (rx_valid !== 1'b1 && n < 100) begin
				@(posedge ref_clk);
				#1;
				n++;
			end
			if (rx_valid !== 1'b1) begin
				fail_count++;
				test_done();
			end
			check(rx_data, q.pop_front());
			rx_ready = 1'b1;
			@(posedge ref_clk);
			#1;
			rx_ready = 1'b0;
			@(posedge ref_clk);
			#1;
		end
		repeat (4) @(posedge ref_clk);
		#1;
		check(9'(rx_valid), 9'h0);
	endtask
	// Main sequence: three strap settings, then a FIFO overflow
	initial begin
		logic [7:0] rb;
		repeat (12) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		for (int m = 0; m < 3; m++) begin
			mode(m == 0, m == 1);
			host.xfer(exp_ser, exp_ser ? 3 : 1, 8'h5a, 1'b0, rb);
			wr(1'b1);
			wr(1'b0);
			rd();
			host_chip_addr = 2'h1;
			wr(1'b0);
			host_chip_addr = 2'h2;
			release_busy();
			drain();
			check(9'(serial_mode), 9'(exp_ser));
			check(9'(addr_enable), 9'(exp_ae));
			$display("strap test %0d done", m);
		end
		for (int i = 0; i < LHP_FIFO_DEPTH + 1; i++) begin
			wr(1'b0);
			release_busy();
		end
		drain();
		$display("overflow test done");
		test_done();
	end
endmodule // lcd_host_serial_parallel_port_tb
